// [tmr_pkg.sv]
// constants and carrier types for the transceiver master reset sequencer
// ************************************************************
// Notes on behaviour
// ************************************************************
// Notes on behaviour
// - sequence pll, oscillator, divider and channel resets with no user help
// - tx order: wait, lc pll, ring pll, divider, channel pma, pcs, idle
// - rx order: wait, lc pll, ring pll, osc, divider, pma, pcs, idle
// - oscillator done chains across lanes before a lane advances
// - no sequence starts by itself after configuration reset
// - rx master reset bit high then low starts that channel's rx sequence
// - rx done drops on master rise, rises after pcs gated by user ok
// - tx master reset bit high then low starts that channel's tx sequence
// - tx done drops on master rise, rises after pcs gated by user ok
// - channel reset pulse resets masked parts, in turn or all at once
// - oscillator done drops on its reset, rises when oscillator ready returns
// - cdr, oob and pcs direct inputs reset their own part only
// - rx pcs mask: oob 4, eye scan 3, buffer 2, prbs 1, pcs top 0
// - mode 00 sequential, 11 single, 01 and 10 reserved
// - enable word holds one bit per channel component in the sequence, pma and pcs sharing one, except rx ring, which has its own enables
package tmr_pkg;
  localparam int NCH = 4;
  localparam int NFSM = 2 * NCH;
  // ************************************************************
  // modes and timing
  // ************************************************************
  localparam logic [1:0] MODE_SEQ = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h3;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RST_PULSE_NS = 200;
  localparam int RST_PULSE_CYC =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] HOLD_CYC = 3'(RST_PULSE_CYC);
  // ************************************************************
  // enable word layout
  // ************************************************************
  localparam int EN_TX_LC_LSB = 0;
  localparam int EN_TX_RING_LSB = 4;
  localparam int EN_CH_LSB = 8;
  localparam int EN_CH_STRIDE = 5;
  localparam int EN_OSC_OFS = 0;
  localparam int EN_TXDIV_OFS = 1;
  localparam int EN_TXCH_OFS = 2;
  localparam int EN_RXDIV_OFS = 3;
  localparam int EN_RXCH_OFS = 4;
  localparam int EN_RX_LC_LSB = 28;
  // ************************************************************
  // rx mask fields
  // ************************************************************
  localparam int RXPCS_OOB = 4;
  localparam int RXPCS_EYE = 3;
  localparam int RXPCS_BUF = 2;
  localparam int RXPCS_PRBS = 1;
  localparam int RXPCS_TOP = 0;
  localparam int RXPMA_CDR_FR = 5;
  localparam int RXPMA_CDR_PH = 4;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum {ST_WAIT, ST_LC, ST_RING, ST_OSC, ST_DIV, ST_PMA, ST_PCS,
    ST_IDLE} tmr_state_e;
  typedef struct packed {
    logic [1:0] txMode;
    logic [1:0] rxMode;
    logic [2:0] txPmaMask;
    logic txPcsMask;
    logic [6:0] rxPmaMask;
    logic [4:0] rxPcsMask;
    logic txMasterReset;
    logic rxMasterReset;
    logic txChannelReset;
    logic rxChannelReset;
    logic txDividerReset;
    logic rxDividerReset;
    logic oscReset;
    logic cdrDirect;
    logic oobDirect;
    logic pcsDirect;
    logic txUserClockOk;
    logic rxUserClockOk;
    logic txPmaReady;
    logic rxPmaReady;
    logic oscReady;
  } tmr_chin_s;
  typedef struct packed {
    tmr_chin_s [NCH-1:0] ch;
    logic [31:0] masterSequenceEnables;
    logic [NCH-1:0] rxRingEnables;
    logic [NCH-1:0] oscChainSel;
    logic quadPowerGood;
    logic lcPllLocked;
    logic ringPllLocked;
    logic lcPllResetIn;
    logic ringPllResetIn;
  } tmr_in_s;
  typedef struct packed {
    logic txDiv;
    logic rxDiv;
    logic osc;
    logic [2:0] txPma;
    logic txPcs;
    logic [6:0] rxPma;
    logic [4:0] rxPcs;
  } tmr_rst_s;
endpackage : tmr_pkg

// [tmr_master_reset.sv]
// per-channel tx and rx master reset sequencers for a four-channel quad
`timescale 1ns/100ps
module tmr_master_reset (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire tmr_pkg::tmr_in_s pinIn,
  output logic lcPllResetOut,
  output logic ringPllResetOut,
  output tmr_pkg::tmr_rst_s [tmr_pkg::NCH-1:0] chanResetOut,
  output logic [tmr_pkg::NCH-1:0] oscResetDone,
  output logic [tmr_pkg::NCH-1:0] txMasterDone,
  output logic [tmr_pkg::NCH-1:0] rxMasterDone
);
  import tmr_pkg::*;

  // ************************************************************
  // input synchroniser
  // ************************************************************
  tmr_in_s syncA_reg;
  tmr_in_s syncB_reg;
  tmr_in_s prev_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      prev_reg <= '0;
    end else if (ce) begin
      syncA_reg <= pinIn;
      syncB_reg <= syncA_reg;
      prev_reg <= syncB_reg;
    end
  end

  // next state after the current one, skipping disabled steps
  function automatic tmr_state_e nextStep(tmr_state_e cur,
                                          logic [7:0] en);
    tmr_state_e r;
    r = ST_IDLE;
    for (int i = 7; i > int'(cur); i--) begin
      if (en[i]) begin
        r = tmr_state_e'(i);
      end
    end
    return r;
  endfunction : nextStep

  // ************************************************************
  // per-sequencer decode; index 0-3 tx, 4-7 rx
  // ************************************************************
  logic [NFSM-1:0] mstNow, mstRise, chFall, single, userOk, pmaOk;
  logic [7:0] en [NFSM];
  logic oscChainOk;

  always_comb begin
    int c;
    logic tx;
    tmr_chin_s s;
    tmr_chin_s p;
    logic [31:0] e;
    c = 0;
    tx = 1'b0;
    s = '0;
    p = '0;
    e = syncB_reg.masterSequenceEnables;
    // a lane waits until every chained lane's oscillator is done
    oscChainOk = &(oscResetDone | ~syncB_reg.oscChainSel);
    for (int f = 0; f < NFSM; f++) begin
      c = f % NCH;
      tx = f < NCH;
      s = syncB_reg.ch[c];
      p = prev_reg.ch[c];
      mstNow[f] = tx ? s.txMasterReset : s.rxMasterReset;
      mstRise[f] = mstNow[f] && !(tx ? p.txMasterReset : p.rxMasterReset);
      chFall[f] = tx ? (p.txChannelReset && !s.txChannelReset)
                     : (p.rxChannelReset && !s.rxChannelReset);
      single[f] = (tx ? s.txMode : s.rxMode) == MODE_SINGLE;
      userOk[f] = tx ? s.txUserClockOk : s.rxUserClockOk;
      pmaOk[f] = tx ? s.txPmaReady : s.rxPmaReady;
      en[f] = '1;
      en[f][ST_LC] = tx ? e[EN_TX_LC_LSB + c] : e[EN_RX_LC_LSB + c];
      en[f][ST_RING] = tx ? e[EN_TX_RING_LSB + c]
                          : syncB_reg.rxRingEnables[c];
      en[f][ST_OSC] = !tx && e[EN_CH_LSB + EN_CH_STRIDE * c + EN_OSC_OFS];
      en[f][ST_DIV] = e[EN_CH_LSB + EN_CH_STRIDE * c +
                        (tx ? EN_TXDIV_OFS : EN_RXDIV_OFS)];
      en[f][ST_PMA] = e[EN_CH_LSB + EN_CH_STRIDE * c +
                        (tx ? EN_TXCH_OFS : EN_RXCH_OFS)];
      en[f][ST_PCS] = en[f][ST_PMA];
    end
  end

  // ************************************************************
  // sequencers
  // ************************************************************
  tmr_state_e state_reg [NFSM];
  tmr_state_e state_next [NFSM];
  logic [2:0] cnt_reg [NFSM];
  logic [2:0] cnt_next [NFSM];
  logic [NFSM-1:0] single_reg, single_next;
  logic [NFSM-1:0] master_reg, master_next;
  logic [NFSM-1:0] done_reg, done_next;

  always_comb begin
    logic ok;
    ok = 1'b0;
    for (int f = 0; f < NFSM; f++) begin
      state_next[f] = state_reg[f];
      cnt_next[f] = cnt_reg[f];
      single_next[f] = single_reg[f];
      master_next[f] = master_reg[f];
      done_next[f] = done_reg[f];
      unique case (state_reg[f])
        ST_LC: ok = syncB_reg.lcPllLocked;
        ST_RING: ok = syncB_reg.ringPllLocked;
        ST_OSC: ok = oscChainOk;
        ST_DIV: ok = 1'b1;
        ST_PMA: ok = pmaOk[f] && (!single_reg[f] || userOk[f]);
        ST_PCS: ok = userOk[f];
        ST_WAIT, ST_IDLE: ok = 1'b0;
      endcase
      if (mstRise[f]) begin
        // parked in wait while the master input stays high
        state_next[f] = ST_WAIT;
        master_next[f] = 1'b1;
        single_next[f] = 1'b0;
        done_next[f] = 1'b0;
        cnt_next[f] = '0;
      end else begin
        unique case (state_reg[f])
          ST_WAIT: begin
            if (!mstNow[f] && syncB_reg.quadPowerGood) begin
              state_next[f] = nextStep(ST_WAIT, en[f]);
            end
          end
          ST_IDLE: begin
            // only a channel pulse or a master rise leaves idle; nothing starts alone
            if (chFall[f]) begin
              state_next[f] = ST_PMA;
              single_next[f] = single[f];
              master_next[f] = 1'b0;
            end
          end
          default: begin
            if (cnt_reg[f] != HOLD_CYC) begin
              cnt_next[f] = cnt_reg[f] + 3'h1;
            end else if (ok) begin
              cnt_next[f] = '0;
              if (master_reg[f]) begin
                state_next[f] = nextStep(state_reg[f], en[f]);
              end else if (state_reg[f] == ST_PMA && !single_reg[f]) begin
                state_next[f] = ST_PCS;
              end else begin
                state_next[f] = ST_IDLE;
              end
              if (state_next[f] == ST_IDLE && master_reg[f]) begin
                done_next[f] = 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      for (int f = 0; f < NFSM; f++) begin
        state_reg[f] <= ST_IDLE;
        cnt_reg[f] <= '0;
      end
      single_reg <= '0;
      master_reg <= '0;
      done_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      single_reg <= single_next;
      master_reg <= master_next;
      done_reg <= done_next;
    end
  end

  // ************************************************************
  // component reset outputs
  // ************************************************************
  tmr_rst_s [NCH-1:0] rst_reg, rst_next;
  logic lcRst_reg, lcRst_next, ringRst_reg, ringRst_next;
  logic [NCH-1:0] oscDone_reg, oscDone_next;

  always_comb begin
    logic act;
    int c;
    tmr_chin_s s;
    act = 1'b0;
    c = 0;
    s = '0;
    lcRst_next = syncB_reg.lcPllResetIn;
    ringRst_next = syncB_reg.ringPllResetIn;
    for (int k = 0; k < NCH; k++) begin
      s = syncB_reg.ch[k];
      rst_next[k] = '0;
      rst_next[k].txDiv = s.txDividerReset;
      rst_next[k].rxDiv = s.rxDividerReset;
      rst_next[k].osc = s.oscReset;
      // direct inputs ignore mode and masks
      rst_next[k].rxPma[RXPMA_CDR_FR] = s.cdrDirect;
      rst_next[k].rxPma[RXPMA_CDR_PH] = s.cdrDirect;
      rst_next[k].rxPcs[RXPCS_OOB] = s.oobDirect;
      rst_next[k].rxPcs[RXPCS_TOP] = s.pcsDirect;
    end
    for (int f = 0; f < NFSM; f++) begin
      c = f % NCH;
      s = syncB_reg.ch[c];
      act = cnt_reg[f] != HOLD_CYC;
      if (act) begin
        unique case (state_reg[f])
          ST_LC: lcRst_next = 1'b1;
          ST_RING: ringRst_next = 1'b1;
          ST_OSC: rst_next[c].osc = 1'b1;
          ST_DIV: begin
            if (f < NCH) begin
              rst_next[c].txDiv = 1'b1;
            end else begin
              rst_next[c].rxDiv = 1'b1;
            end
          end
          ST_PMA, ST_PCS: begin
            // single mode fires pma and pcs masks together
            if (f < NCH) begin
              if (state_reg[f] == ST_PMA) begin
                rst_next[c].txPma |= s.txPmaMask;
              end
              if (state_reg[f] == ST_PCS || single_reg[f]) begin
                rst_next[c].txPcs |= s.txPcsMask;
              end
            end else begin
              if (state_reg[f] == ST_PMA) begin
                rst_next[c].rxPma |= s.rxPmaMask;
              end
              if (state_reg[f] == ST_PCS || single_reg[f]) begin
                rst_next[c].rxPcs |= s.rxPcsMask;
              end
            end
          end
          ST_WAIT, ST_IDLE: ;
        endcase
      end
    end
    for (int k = 0; k < NCH; k++) begin
      // an oscillator reset in flight always beats a stale ready
      if (rst_next[k].osc) begin
        oscDone_next[k] = 1'b0;
      end else if (syncB_reg.ch[k].oscReady) begin
        oscDone_next[k] = 1'b1;
      end else begin
        oscDone_next[k] = oscDone_reg[k];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rst_reg <= '0;
      lcRst_reg <= 1'b0;
      ringRst_reg <= 1'b0;
      oscDone_reg <= '0;
    end else if (ce) begin
      rst_reg <= rst_next;
      lcRst_reg <= lcRst_next;
      ringRst_reg <= ringRst_next;
      oscDone_reg <= oscDone_next;
    end
  end

  assign lcPllResetOut = lcRst_reg;
  assign ringPllResetOut = ringRst_reg;
  assign chanResetOut = rst_reg;
  assign oscResetDone = oscDone_reg;
  assign txMasterDone = done_reg[NCH-1:0];
  assign rxMasterDone = done_reg[NFSM-1:NCH];

  // ************************************************************
  // checks on channel 0
  // ************************************************************
  txdone_drop_a: assert property (@(posedge clock) disable iff (srst)
    ce && mstRise[0] |=> !txMasterDone[0]) else $error("tx done held");
  rxdone_drop_a: assert property (@(posedge clock) disable iff (srst)
    ce && mstRise[4] |=> !rxMasterDone[0]) else $error("rx done held");
  no_selfstart_a: assert property (@(posedge clock) disable iff (srst)
    state_reg[0] == ST_WAIT && $past(state_reg[0]) != ST_WAIT
    |-> $past(mstRise[0])) else $error("tx started alone");
  tx_start_a: assert property (@(posedge clock) disable iff (srst)
    ce && state_reg[0] == ST_WAIT && !mstNow[0] && !mstRise[0]
    && syncB_reg.quadPowerGood |=> state_reg[0] != ST_WAIT)
    else $error("tx did not start");
  pcs_gate_a: assert property (@(posedge clock) disable iff (srst)
    ce && state_reg[0] == ST_PCS && !userOk[0] && !mstRise[0]
    |=> state_reg[0] == ST_PCS) else $error("pcs left early");
  lock_wait_a: assert property (@(posedge clock) disable iff (srst)
    ce && state_reg[0] == ST_LC && !syncB_reg.lcPllLocked && !mstRise[0]
    |=> state_reg[0] == ST_LC) else $error("left lc without lock");
  osc_done_a: assert property (@(posedge clock) disable iff (srst)
    chanResetOut[0].osc |-> !oscResetDone[0]) else $error("osc done high");
  osc_chain_a: assert property (@(posedge clock) disable iff (srst)
    ce && state_reg[4] == ST_OSC && !oscChainOk && !mstRise[4]
    |=> state_reg[4] == ST_OSC) else $error("osc chain ignored");
  div_pulse_a: assert property (@(posedge clock) disable iff (srst)
    ce && $rose(chanResetOut[0].txDiv) && !syncB_reg.ch[0].txDividerReset
    |-> chanResetOut[0].txDiv [*4]) else $error("divider pulse short");
  cdr_direct_a: assert property (@(posedge clock) disable iff (srst)
    ce && syncB_reg.ch[0].cdrDirect |=> chanResetOut[0].rxPma[5:4] == 2'h3)
    else $error("cdr direct lost");
endmodule : tmr_master_reset

// [tmr_far_model.sv]
// analog side model: pll lock, pma ready and oscillator ready per lane
`timescale 1ns/100ps
// ************************************************************
// ready indication that drops under reset and returns after a delay
// ************************************************************
module tmr_ready_dly #(
  parameter int DLY = 6
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic hold,
  output logic ready
);
  logic [7:0] cntReg;
  logic [7:0] cntNext;
  always_comb begin
    cntNext = cntReg;
    if (hold) begin
      cntNext = 8'h00;
    end else if (cntReg < 8'(DLY)) begin
      cntNext = cntReg + 8'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      cntReg <= 8'(DLY);
    end else begin
      cntReg <= cntNext;
    end
  end
  // slow on purpose so the sequencer really has to wait
  assign ready = !hold && (cntReg == 8'(DLY));
endmodule : tmr_ready_dly

// ************************************************************
// far side of the quad
// ************************************************************
module tmr_far_model
  import tmr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic lcPllResetOut,
  input wire logic ringPllResetOut,
  input wire tmr_pkg::tmr_rst_s [tmr_pkg::NCH-1:0] chanResetOut,
  input wire logic [tmr_pkg::NCH-1:0] stall,
  output logic lcPllLocked,
  output logic ringPllLocked,
  output logic [tmr_pkg::NCH-1:0] txPmaReady,
  output logic [tmr_pkg::NCH-1:0] rxPmaReady,
  output logic [tmr_pkg::NCH-1:0] oscReady
);
  tmr_ready_dly lc_inst (.clock(clock), .srst(srst), .hold(lcPllResetOut),
    .ready(lcPllLocked));
  tmr_ready_dly ring_inst (.clock(clock), .srst(srst),
    .hold(ringPllResetOut), .ready(ringPllLocked));
  for (genvar c = 0; c < NCH; c++) begin : g_lane
    tmr_ready_dly tx_inst (.clock(clock), .srst(srst),
      .hold(|chanResetOut[c].txPma), .ready(txPmaReady[c]));
    tmr_ready_dly rx_inst (.clock(clock), .srst(srst),
      .hold(|chanResetOut[c].rxPma), .ready(rxPmaReady[c]));
    // stall keeps a lane's oscillator from settling
    tmr_ready_dly osc_inst (.clock(clock), .srst(srst),
      .hold(chanResetOut[c].osc | stall[c]), .ready(oscReady[c]));
  end
endmodule : tmr_far_model

// [test_transceiver_master_reset_seq.sv]
// self-checking bench for the quad master reset sequencer
`timescale 1ns/100ps
module test_transceiver_master_reset_seq;
  import tmr_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  tmr_in_s drv;
  tmr_in_s pinIn;
  logic [NCH-1:0] stall = '0;
  logic lcPllResetOut, ringPllResetOut, lcLock, ringLock;
  tmr_rst_s [NCH-1:0] chanResetOut;
  logic [NCH-1:0] oscResetDone, txMasterDone, rxMasterDone;
  logic [NCH-1:0] txRdy, rxRdy, oscRdy;
  logic [8:0] cur, prev = '0;
  int seen[$];
  int monCh = 0;
  int fail_count = 0;
  int compares = 0;
  always #25 clock = ~clock;
  always_comb begin
    pinIn = drv;
    pinIn.lcPllLocked = lcLock;
    pinIn.ringPllLocked = ringLock;
    for (int c = 0; c < NCH; c++) begin
      pinIn.ch[c].txPmaReady = txRdy[c];
      pinIn.ch[c].rxPmaReady = rxRdy[c];
      pinIn.ch[c].oscReady = oscRdy[c];
    end
  end
  tmr_master_reset tmr_master_reset_inst (.clock(clock), .srst(srst),
    .ce(ce), .pinIn(pinIn), .lcPllResetOut(lcPllResetOut),
    .ringPllResetOut(ringPllResetOut), .chanResetOut(chanResetOut),
    .oscResetDone(oscResetDone), .txMasterDone(txMasterDone),
    .rxMasterDone(rxMasterDone));
  tmr_far_model tmr_far_model_inst (.clock(clock), .srst(srst),
    .lcPllResetOut(lcPllResetOut), .ringPllResetOut(ringPllResetOut),
    .chanResetOut(chanResetOut), .stall(stall), .lcPllLocked(lcLock),
    .ringPllLocked(ringLock), .txPmaReady(txRdy), .rxPmaReady(rxRdy),
    .oscReady(oscRdy));
  // ************************************************************
  // step trace: 1 lc 2 ring 3 osc 4 txdiv 5 rxdiv 6..9 tx/rx pma,pcs
  // ************************************************************
  always @(posedge clock) begin
    cur = {|chanResetOut[monCh].rxPcs, |chanResetOut[monCh].rxPma,
      chanResetOut[monCh].txPcs, |chanResetOut[monCh].txPma,
      chanResetOut[monCh].rxDiv, chanResetOut[monCh].txDiv,
      chanResetOut[monCh].osc, ringPllResetOut, lcPllResetOut};
    for (int i = 0; i < 9; i++) begin
      if (cur[i] && !prev[i]) seen.push_back(i + 1);
    end
    prev = cur;
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task step(input int n);
    repeat (n) @(negedge clock);
  endtask : step
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : chk
  task waitSeen(input int n);
    int k;
    k = 0;
    while (seen.size() < n && k < 400) begin
      step(1);
      k++;
    end
    chk("trace length", 32'(n), 32'(seen.size()));
  endtask : waitSeen
  task chkTrace(input int exp[$]);
    chk("trace length", 32'(exp.size()), 32'(seen.size()));
    foreach (exp[i]) begin
      if (i < seen.size()) chk("trace step", 32'(exp[i]), 32'(seen[i]));
    end
  endtask : chkTrace
  task master(input bit rx, input int c);
    if (rx) drv.ch[c].rxMasterReset = 1'b1;
    else drv.ch[c].txMasterReset = 1'b1;
    step(2);
    drv.ch[c].txMode = MODE_SEQ;
    drv.ch[c].rxMode = MODE_SEQ;
    drv.ch[c].txPmaMask = 3'h7;
    drv.ch[c].txPcsMask = 1'b1;
    drv.ch[c].rxPmaMask = 7'h7F;
    drv.ch[c].rxPcsMask = 5'h1F;
    step(8);
    chk("done drops", 0, rx ? rxMasterDone[c] : txMasterDone[c]);
    chk("power good", 1, drv.quadPowerGood);
    drv.ch[c].rxMasterReset = 1'b0;
    drv.ch[c].txMasterReset = 1'b0;
  endtask : master
  task waitDone(input bit rx, input int c);
    int k;
    k = 0;
    while ((rx ? rxMasterDone[c] : txMasterDone[c]) !== 1'b1 && k < 600) begin
      step(1);
      k++;
    end
    chk("master done", 1, rx ? rxMasterDone[c] : txMasterDone[c]);
  endtask : waitDone
  task end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    drv = '0;
    drv.quadPowerGood = 1'b1;
    for (int c = 0; c < NCH; c++) begin
      drv.ch[c].txMode = MODE_SINGLE;
      drv.ch[c].rxMode = MODE_SINGLE;
    end
    step(8);
    srst = 1'b0;
    step(40);
    chk("tx done idle", 0, 32'(txMasterDone));
    chk("no sequence", 0, 32'(seen.size()));
    drv.masterSequenceEnables = 32'hFFFFFFFF;
    drv.rxRingEnables = 4'hF;
    master(0, 0);
    waitSeen(5);
    step(20);
    chk("tx done gated", 0, txMasterDone[0]);
    drv.ch[0].txUserClockOk = 1'b1;
    waitDone(0, 0);
    chkTrace({1, 2, 4, 6, 7});
    drv.masterSequenceEnables = 32'h00000400;
    seen.delete();
    master(0, 0);
    waitDone(0, 0);
    chkTrace({6, 7});
    drv.masterSequenceEnables = 32'hFFFFFFFF;
    // two lanes on one shared pll must run their master resets together
    drv.ch[2].txUserClockOk = 1'b1;
    drv.ch[3].txUserClockOk = 1'b1;
    drv.ch[3].txMode = MODE_SEQ;
    drv.ch[3].txPmaMask = 3'h7;
    drv.ch[3].txPcsMask = 1'b1;
    drv.ch[3].txMasterReset = 1'b1;
    master(0, 2);
    drv.ch[3].txMasterReset = 1'b0;
    waitDone(0, 2);
    waitDone(0, 3);
    drv.oscChainSel = 4'h6;
    stall = 4'h4;
    drv.ch[2].oscReset = 1'b1;
    step(3);
    drv.ch[2].oscReset = 1'b0;
    step(6);
    chk("osc done lane2", 0, oscResetDone[2]);
    monCh = 1;
    seen.delete();
    drv.ch[1].rxUserClockOk = 1'b1;
    master(1, 1);
    waitSeen(3);
    chk("osc done lane1", 0, oscResetDone[1]);
    step(30);
    chk("chain holds", 3, 32'(seen.size()));
    stall = 4'h0;
    waitDone(1, 1);
    chkTrace({1, 2, 3, 5, 8, 9});
    chk("osc done back", 1, oscResetDone[1]);
    monCh = 0;
    for (int m = 0; m < 3; m++) begin
      drv.ch[0].txMode = (m == 1) ? MODE_SINGLE : 2'(m == 2 ? 1 : 0);
      step(4);
      seen.delete();
      drv.ch[0].txChannelReset = 1'b1;
      step(3);
      drv.ch[0].txChannelReset = 1'b0;
      // single mode raises pma and pcs on the same edge
      waitSeen(m == 1 ? 2 : 1);
      chk("pcs with pma", 32'(m == 1), chanResetOut[0].txPcs);
      step(40);
      chk("done kept", 1, txMasterDone[0]);
    end
    drv.ch[0].oobDirect = 1'b1;
    step(5);
    chk("oob direct", 5'h10, chanResetOut[0].rxPcs);
    drv.ch[0].oobDirect = 1'b0;
    drv.ch[0].cdrDirect = 1'b1;
    step(5);
    chk("cdr direct", 7'h30, chanResetOut[0].rxPma);
    drv.ch[0].cdrDirect = 1'b0;
    drv.ch[0].pcsDirect = 1'b1;
    step(5);
    chk("pcs direct", 5'h01, chanResetOut[0].rxPcs);
    // with the enable low even the synchronisers must hold
    ce = 1'b0;
    drv.ch[0].pcsDirect = 1'b0;
    step(5);
    chk("ce freezes", 5'h01, chanResetOut[0].rxPcs);
    ce = 1'b1;
    step(5);
    chk("ce resumes", 0, chanResetOut[0].rxPcs);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    end_sim();
  end
endmodule : test_transceiver_master_reset_seq
